// *** pkg/adcif_pkg.sv ***
// ****************************************************************
// Shared constants of the converter event flag block.
// ****************************************************************
package adcif_pkg;

  // ****************************************************************
  // Bus geometry.
  // ****************************************************************
  // Byte address width of the register window.
  localparam int ADDR_W = 8;
  // Data width of the register bus.
  localparam int DATA_W = 32;
  // Width of a register index; the byte address is four times the index.
  localparam int IDX_W = 6;

  // ****************************************************************
  // Register indices, byte address = index * 4.
  // ****************************************************************
  // Window mode control register.
  localparam logic [IDX_W-1:0] IDX_WINDOW_MODE = 6'h04;
  // Interrupt enable control register.
  localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 6'h0a;
  // Event flag register.
  localparam logic [IDX_W-1:0] IDX_EVENT_FLAGS = 6'h0b;
  // Conversion result register, read only.
  localparam logic [IDX_W-1:0] IDX_RESULT = 6'h10;
  // Window low threshold register.
  localparam logic [IDX_W-1:0] IDX_LOW_THR = 6'h12;
  // Window high threshold register.
  localparam logic [IDX_W-1:0] IDX_HIGH_THR = 6'h14;

  // ****************************************************************
  // Field positions and widths.
  // ****************************************************************
  // Number of event flags.
  localparam int FLAG_W = 2;
  // Result ready flag position.
  localparam int BIT_RESULT_READY = 0;
  // Window match flag position.
  localparam int BIT_WINDOW_MATCH = 1;
  // Width of the window compare select field.
  localparam int MODE_W = 3;
  // Width of results and thresholds.
  localparam int RES_W = 16;

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam logic [MODE_W-1:0] WINDOW_MODE_RESET = 3'h0;
  localparam logic [RES_W-1:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [RES_W-1:0] RESULT_RESET = 16'h0000;

  // ****************************************************************
  // Bus responses.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Window comparison modes; the other codes are reserved.
  typedef enum logic [MODE_W-1:0] {
    WMODE_NONE = 3'h0,
    WMODE_BELOW = 3'h1,
    WMODE_ABOVE = 3'h2,
    WMODE_INSIDE = 3'h3,
    WMODE_OUTSIDE = 3'h4
  } adcif_wmode_e;

endpackage

// *** hw/adcif_window_cmp.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Window comparator on the finished result.
// ****************************************************************
module adcif_window_cmp (
  input wire logic [adcif_pkg::MODE_W-1:0] mode, // Window compare select.
  input wire logic [adcif_pkg::RES_W-1:0] result, // Finished, possibly accumulated result.
  input wire logic [adcif_pkg::RES_W-1:0] low_thr, // Low threshold.
  input wire logic [adcif_pkg::RES_W-1:0] high_thr, // High threshold.
  output logic match // High when the result fits the mode.
);

  // The two raw comparisons are unsigned; full scale is all ones.
  logic below; // Result under the low threshold.
  logic above; // Result over the high threshold.

  assign below = result < low_thr;
  assign above = result > high_thr;

  // Select the comparison named by the mode; reserved codes never match.
  always_comb begin
    unique case (mode)
      adcif_pkg::WMODE_NONE: begin
        match = 1'b0; // No comparison at all.
      end
      adcif_pkg::WMODE_BELOW: begin
        match = below;
      end
      adcif_pkg::WMODE_ABOVE: begin
        match = above;
      end
      adcif_pkg::WMODE_INSIDE: begin
        match = (result > low_thr) && (result < high_thr);
      end
      adcif_pkg::WMODE_OUTSIDE: begin
        match = below || above;
      end
      default: begin
        match = 1'b0; // Reserved codes behave as no comparison.
      end
    endcase
  end

endmodule // adcif_window_cmp

// *** hw/adcif_flags.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Window match sets bit one at finish.
// - Compare only once, when conversion finishes.
// - Window flag cleared by one-write or result read.
// - Result ready sets bit zero at finish.
// - Ready flag cleared by one-write or result read.
// - Writing zero leaves a flag alone.
// - Flag register index 0x0B, resets to zero.
// - Three-bit mode: none, below, above, inside, outside.
// - Flag interrupts only when its enable set.
// - Accumulated result compared, not single samples.
module adcif_flags (
  input wire logic core_clk, // Peripheral clock, 40 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic conv_done, // One-cycle pulse at end of a measurement.
  input wire logic [adcif_pkg::RES_W-1:0] conv_result, // Final accumulated result.
  input wire logic [adcif_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [adcif_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [adcif_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [adcif_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic irq // Level interrupt request, active high.
);

  // ****************************************************************
  // Reset release.
  // ****************************************************************

  logic [1:0] rst_sync_q; // Two-stage release of the reset.
  logic rst_n_sync; // Released reset used by all other logic.

  // The reset asserts at once and releases two edges later.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_sync = rst_sync_q[1];

  // ****************************************************************
  // State of the block.
  // ****************************************************************

  typedef struct packed {
    logic aw_got; // A write address is held.
    logic w_got; // A write data beat is held.
    logic [adcif_pkg::ADDR_W-1:0] waddr; // Held write address.
    logic [adcif_pkg::DATA_W-1:0] wdata; // Held write data.
    logic [3:0] wstrb; // Held write strobes.
    logic bvalid; // Write response pending.
    logic [1:0] bresp; // Write response code.
    logic rvalid; // Read data pending.
    logic [adcif_pkg::DATA_W-1:0] rdata; // Read data.
    logic [1:0] rresp; // Read response code.
    logic [adcif_pkg::FLAG_W-1:0] flags; // Sticky event flags.
    logic [adcif_pkg::FLAG_W-1:0] irq_en; // Interrupt enables.
    logic [adcif_pkg::MODE_W-1:0] mode; // Window compare select.
    logic [adcif_pkg::RES_W-1:0] result; // Latched conversion result.
    logic [adcif_pkg::RES_W-1:0] low_thr; // Window low threshold.
    logic [adcif_pkg::RES_W-1:0] high_thr; // Window high threshold.
  } adcif_state_s;

  adcif_state_s st_q; // Registered state.
  adcif_state_s st_d; // Next state.

  // ****************************************************************
  // Decode and events.
  // ****************************************************************

  logic match; // Live window comparison of the incoming result.
  logic commit; // Both halves of a write are held this cycle.
  logic [adcif_pkg::IDX_W-1:0] wr_idx; // Index of the held write.
  logic ar_take; // A read address is accepted this cycle.
  logic [adcif_pkg::IDX_W-1:0] rd_idx; // Index of the offered read.
  logic rd_clear; // Result register is being read.
  logic [adcif_pkg::FLAG_W-1:0] set_vec; // Hardware flag sets.
  logic [adcif_pkg::FLAG_W-1:0] clr_vec; // Software flag clears.

  // The sequencer hands over the accumulated value, which is compared.
  adcif_window_cmp u_cmp (
    .mode(st_q.mode),
    .result(conv_result),
    .low_thr(st_q.low_thr),
    .high_thr(st_q.high_thr),
    .match(match)
  );

  assign commit = st_q.aw_got && st_q.w_got;
  assign wr_idx = st_q.waddr[adcif_pkg::ADDR_W-1:2];
  assign ar_take = s_axi_arvalid && !st_q.rvalid;
  assign rd_idx = s_axi_araddr[adcif_pkg::ADDR_W-1:2];
  assign rd_clear = ar_take && (rd_idx == adcif_pkg::IDX_RESULT);

  // Ready flags show whether a channel can take a new item.
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // Each enabled flag drives the single interrupt line.
  assign irq = |(st_q.flags & st_q.irq_en);

  // Both flags are set only by the end-of-conversion strobe.
  always_comb begin
    set_vec = '0;
    set_vec[adcif_pkg::BIT_RESULT_READY] = conv_done;
    set_vec[adcif_pkg::BIT_WINDOW_MATCH] = conv_done && match;
  end

  // Only bits written as one clear; zeros leave flags alone.
  always_comb begin
    clr_vec = '0;
    if (commit && (wr_idx == adcif_pkg::IDX_EVENT_FLAGS) && st_q.wstrb[0]) begin
      clr_vec = st_q.wdata[adcif_pkg::FLAG_W-1:0];
    end
    if (rd_clear) begin
      clr_vec = '1; // Reading the result clears both flags.
    end
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // All bus and register updates are computed into one copy here.
  always_comb begin
    st_d = st_q;
    // Capture the write address when offered.
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.waddr = s_axi_awaddr;
    end
    // Capture the write data when offered, in either order.
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    // Retire a finished write response.
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Perform the held write and raise the response.
    if (commit) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = adcif_pkg::RESP_OKAY;
      unique case (wr_idx)
        adcif_pkg::IDX_WINDOW_MODE: begin
          if (st_q.wstrb[0]) begin
            st_d.mode = st_q.wdata[adcif_pkg::MODE_W-1:0];
          end
        end
        adcif_pkg::IDX_INT_ENABLE: begin
          if (st_q.wstrb[0]) begin
            st_d.irq_en = st_q.wdata[adcif_pkg::FLAG_W-1:0];
          end
        end
        adcif_pkg::IDX_EVENT_FLAGS: begin
          st_d.bresp = adcif_pkg::RESP_OKAY; // Clearing is done below.
        end
        adcif_pkg::IDX_RESULT: begin
          st_d.bresp = adcif_pkg::RESP_OKAY; // Read only; the write is dropped.
        end
        adcif_pkg::IDX_LOW_THR: begin
          if (st_q.wstrb[0]) begin
            st_d.low_thr[7:0] = st_q.wdata[7:0];
          end
          if (st_q.wstrb[1]) begin
            st_d.low_thr[15:8] = st_q.wdata[15:8];
          end
        end
        adcif_pkg::IDX_HIGH_THR: begin
          if (st_q.wstrb[0]) begin
            st_d.high_thr[7:0] = st_q.wdata[7:0];
          end
          if (st_q.wstrb[1]) begin
            st_d.high_thr[15:8] = st_q.wdata[15:8];
          end
        end
        default: begin
          st_d.bresp = adcif_pkg::RESP_SLVERR; // Unmapped address.
        end
      endcase
    end
    // Retire finished read data.
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Answer a read one cycle after the address is taken.
    if (ar_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = adcif_pkg::RESP_OKAY;
      unique case (rd_idx)
        adcif_pkg::IDX_WINDOW_MODE: begin
          st_d.rdata = {29'h0, st_q.mode};
        end
        adcif_pkg::IDX_INT_ENABLE: begin
          st_d.rdata = {30'h0, st_q.irq_en};
        end
        adcif_pkg::IDX_EVENT_FLAGS: begin
          st_d.rdata = {30'h0, st_q.flags};
        end
        adcif_pkg::IDX_RESULT: begin
          st_d.rdata = {16'h0, st_q.result};
        end
        adcif_pkg::IDX_LOW_THR: begin
          st_d.rdata = {16'h0, st_q.low_thr};
        end
        adcif_pkg::IDX_HIGH_THR: begin
          st_d.rdata = {16'h0, st_q.high_thr};
        end
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = adcif_pkg::RESP_SLVERR; // Unmapped address.
        end
      endcase
    end
    // A fresh result is latched at the end of every measurement.
    if (conv_done) begin
      st_d.result = conv_result;
    end
    // The set term is applied last so it wins over a clear.
    st_d.flags = (st_q.flags & ~clr_vec) | set_vec;
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // All state starts from its documented value after reset.
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_q <= '0;
      st_q.flags <= adcif_pkg::EVENT_FLAGS_RESET[adcif_pkg::FLAG_W-1:0];
      st_q.irq_en <= adcif_pkg::INT_ENABLE_RESET[adcif_pkg::FLAG_W-1:0];
      st_q.mode <= adcif_pkg::WINDOW_MODE_RESET;
      st_q.result <= adcif_pkg::RESULT_RESET;
      st_q.low_thr <= adcif_pkg::THRESHOLD_RESET;
      st_q.high_thr <= adcif_pkg::THRESHOLD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync);

  // A measurement ends with a result below the low threshold in below mode.
  sequence done_below_s;
    conv_done && (st_q.mode == adcif_pkg::WMODE_BELOW) && (conv_result < st_q.low_thr);
  endsequence

  // A flag clear by writing one, with no finishing measurement.
  sequence w1c_match_s;
    commit && (wr_idx == adcif_pkg::IDX_EVENT_FLAGS) && st_q.wstrb[0] && st_q.wdata[1]
      && !conv_done;
  endsequence

  ready_set_a: assert property (conv_done |=> st_q.flags[0])
    else $error("result ready flag not set after conversion");
  match_set_a: assert property (conv_done && match |=> st_q.flags[1])
    else $error("window match flag not set on match");
  match_only_done_a: assert property ($rose(st_q.flags[1]) |-> $past(conv_done))
    else $error("window match flag rose without conversion end");
  below_mode_a: assert property (done_below_s |=> st_q.flags[1] ##1 1'b1)
    else $error("below mode did not set window match flag");
  w1c_clear_a: assert property (w1c_match_s ##0 !rd_clear |=> !st_q.flags[1])
    else $error("write one did not clear window match flag");
  read_clear_a: assert property (rd_clear && !conv_done |=> st_q.flags == 2'b00)
    else $error("result read did not clear flags");
  zero_write_a: assert property (commit && (wr_idx == adcif_pkg::IDX_EVENT_FLAGS)
      && (st_q.wdata[1:0] == 2'b00) && !rd_clear |=> st_q.flags == ($past(st_q.flags)
      | $past(set_vec)))
    else $error("writing zero changed a flag");
  flag_read_a: assert property (ar_take && (rd_idx == adcif_pkg::IDX_EVENT_FLAGS)
      |=> s_axi_rvalid && (s_axi_rdata == {30'h0, $past(st_q.flags)}))
    else $error("flag register read returned wrong value");
  irq_mask_a: assert property (st_q.flags[1] && !st_q.irq_en[1] && !st_q.irq_en[0]
      |-> !irq)
    else $error("masked flag raised interrupt");
  set_wins_a: assert property (conv_done && rd_clear |=> st_q.flags[0] ##1 1'b1)
    else $error("clear beat a same-cycle set");

endmodule // adcif_flags

// *** tb/adcif_seq_model.sv ***
`timescale 1ns/1ps
// ******
// Conversion sequencer model: one finish pulse per request.
// ******
module adcif_seq_model (
  input wire logic core_clk, // Peripheral clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic go, // One-cycle request for a measurement.
  input wire logic [15:0] val, // Result that the measurement gives.
  input wire logic [3:0] lag, // Cycles from request to finish.
  output logic conv_done, // One-cycle finish pulse.
  output logic [15:0] conv_result // Result, valid only with the pulse.
);
  logic [3:0] cnt_q; // Cycles left until the finish pulse.
  logic [15:0] val_q; // Result held for the finish pulse.
  // Outside the pulse the result toggles, so stale data is never trusted.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      val_q <= 16'h0000;
      conv_done <= 1'b0;
      conv_result <= 16'h5a5a;
    end else begin
      conv_done <= (cnt_q == 4'h1);
      conv_result <= (cnt_q == 4'h1) ? val_q : ~conv_result;
      if (go) begin
        cnt_q <= lag;
        val_q <= val;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // adcif_seq_model

// *** tb/adc_interrupt_flag_logic_bench.sv ***
`timescale 1ns/1ps
// ******
// Bench: register accesses against measured conversions.
// ******
module adc_interrupt_flag_logic_bench;
  localparam logic [5:0] FLG = adcif_pkg::IDX_EVENT_FLAGS; // Flag register.
  localparam logic [5:0] ENA = adcif_pkg::IDX_INT_ENABLE; // Enable register.
  localparam logic [5:0] MOD = adcif_pkg::IDX_WINDOW_MODE; // Mode register.
  localparam logic [5:0] RSI = adcif_pkg::IDX_RESULT; // Result register.
  localparam logic [1:0] OK = adcif_pkg::RESP_OKAY; // Good response.
  localparam logic [1:0] ERR = adcif_pkg::RESP_SLVERR; // Refused response.
  localparam logic [15:0] LO = 16'h0100; // Low threshold used.
  localparam logic [15:0] HI = 16'h0200; // High threshold used.
  logic core_clk, rst_n, go, conv_done; // Clock, reset, model request, finish.
  logic [3:0] lag; // Model latency.
  logic [15:0] val, conv_result; // Model result in and out.
  logic [7:0] s_axi_awaddr, s_axi_araddr; // Bus addresses.
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // Write handshakes.
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // Response handshakes.
  logic s_axi_rvalid, s_axi_rready, irq; // Read handshake and interrupt.
  logic [31:0] s_axi_wdata, s_axi_rdata; // Bus data.
  logic [3:0] s_axi_wstrb; // Byte strobes.
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses.
  logic [15:0] tv [5] = '{16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0280}; // Results.
  logic [31:0] e; // Expected flag value.
  int mismatches = 0; // Failed comparisons.
  int cmp_count = 0; // All comparisons.
  adcif_flags u_adcif_flags (.core_clk(core_clk), .rst_n(rst_n), .conv_done(conv_done),
    .conv_result(conv_result), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq));
  adcif_seq_model u_adcif_seq_model (.core_clk(core_clk), .rst_n(rst_n), .go(go),
    .val(val), .lag(lag), .conv_done(conv_done), .conv_result(conv_result));
  // Clock of 25 ns period.
  always #12.5 core_clk = ~core_clk;
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Bus write; handshakes are judged on values settled before the edge.
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 200) begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!b) mismatches++;
  endtask
  // Bus read with comparison of data and response.
  task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar, r;
    n = 0;
    r = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 200) begin
      @(negedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      if (r) chk(s_axi_rdata, ed);
      if (r) chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!r) mismatches++;
  endtask
  // One measurement; returns once its flags have landed.
  task automatic measure(input logic [15:0] v);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    val <= v;
    lag <= 4'h3;
    @(posedge core_clk);
    go <= 1'b0;
    while (!conv_done && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (!conv_done) mismatches++;
    @(posedge core_clk);
  endtask
  // Expected window decision for a mode and a result.
  function automatic logic fit(input logic [2:0] m, input logic [15:0] v);
    case (m)
      3'h1: return v < LO;
      3'h2: return v > HI;
      3'h3: return (v > LO) && (v < HI);
      3'h4: return (v < LO) || (v > HI);
      default: return 1'b0;
    endcase
  endfunction
  // Hang guard, well beyond the expected run of under two thousand cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
  // ******
  // Main sequence.
  // ******
  initial begin
    {core_clk, rst_n, go, lag, val} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(FLG, 32'h0, OK);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(6'h3f, 32'h0, ERR);
    wr(6'h3f, 32'h1, ERR);
    $display("test reset done");
    wr(adcif_pkg::IDX_LOW_THR, {16'h0, LO}, OK);
    wr(adcif_pkg::IDX_HIGH_THR, {16'h0, HI}, OK);
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 5; k++) begin
        wr(MOD, m, OK);
        measure(tv[k]);
        e = {30'h0, fit(m[2:0], tv[k]), 1'b1};
        rd(FLG, e, OK);
        wr(FLG, 32'h0, OK);
        rd(FLG, e, OK);
        wr(FLG, 32'h3, OK);
        rd(FLG, 32'h0, OK);
      end
    end
    $display("test window modes done");
    wr(MOD, 32'h3, OK);
    measure(16'h0180);
    wr(FLG, 32'h1, OK);
    rd(FLG, 32'h2, OK);
    wr(RSI, 32'hffff, OK);
    rd(RSI, 32'h0180, OK);
    rd(FLG, 32'h0, OK);
    measure(16'h0180);
    rd(RSI, 32'h0180, OK);
    rd(FLG, 32'h0, OK);
    $display("test clearing done");
    wr(MOD, 32'h1, OK);
    wr(adcif_pkg::IDX_LOW_THR, 32'h0200, OK);
    rd(FLG, 32'h0, OK);
    measure(16'h0180);
    rd(FLG, 32'h3, OK);
    $display("test compare moment done");
    for (int k = 0; k < 4; k++) begin
      wr(ENA, k, OK);
      rd(ENA, k, OK);
      @(negedge core_clk);
      chk({31'h0, irq}, {31'h0, (k != 0)});
    end
    wr(ENA, 32'h1, OK);
    wr(FLG, 32'h1, OK);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(FLG, 32'h3, OK);
    $display("test interrupt done");
    fork
      begin
        @(posedge core_clk);
        go <= 1'b1;
        val <= 16'h0180;
        lag <= 4'h2;
        @(posedge core_clk);
        go <= 1'b0;
      end
      begin
        repeat (3) @(posedge core_clk);
        rd(RSI, 32'h0180, OK);
      end
    join
    rd(FLG, 32'h3, OK);
    $display("test set against clear done");
    close_out();
  end
endmodule // adc_interrupt_flag_logic_bench
